/* hw/eeprom_pkg.sv */
// constants, types and helpers shared by the serial eeprom slave
// assumes a 20 MHz sys_clk and a synchronous active-low reset
// How it works
// R1: storage is 16-byte pages; 8, 16, 32, 64 or 128 pages by variant
// R2: master sends address then 1..16 bytes; buffered, committed in one cycle
// R3: reads stream bytes, address counter advancing one per delivered byte
// R4: device-select pins are compared with the free bits of the bus address
// R5: serial clock up to 100 kHz standard or 400 kHz fast mode
// R6: write protection blocks programming of the whole array
// R7: ready for commands within 1 ms after power-up
// R8: internal programming cycle completes within 5 ms
// R9: first byte is 1010, three select/array bits, then read-high direction bit
// R10: write increments only low four address bits, wrapping in the page
// R11: write-protect high inhibits all writes; undriven counts as low
// R12: during programming the data line is released and the bus ignored
package eeprom_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int PAGE_BYTES = 16;
   localparam int MAX_PAGES = 128;
   localparam int ADDR_W = 11;
   localparam int PROG_TIME_US = 5000;
   localparam int PROG_CYCLES = PROG_TIME_US * (CLK_HZ / 1_000_000);
   localparam int PWRUP_TIME_US = 1000;
   localparam int PWRUP_CYCLES = PWRUP_TIME_US * (CLK_HZ / 1_000_000);
   localparam int FIFO_DEPTH = 16;
   localparam logic [3:0] DEV_TYPE = 4'hA;
   localparam logic [2:0] VARIANT_MAX = 3'h4;
   localparam logic [2:0] VARIANT_RST = 3'h4;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] ADDR_OFS = 8'h08;
   localparam int STAT_READY = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_WP = 2;
   localparam int STAT_ACTIVE = 3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEV = 3'b001,
      ST_WADDR = 3'b010,
      ST_RX = 3'b011,
      ST_ACK = 3'b100,
      ST_TX = 3'b101,
      ST_MACK = 3'b110
   } link_state_t;

   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } ahb_req_t;

   typedef struct packed {
      logic [2:0] devSelect;
      logic writeProtect;
   } strap_t;

   // select bits still compared with pins for a variant
   function automatic logic [2:0] selMask(input logic [2:0] variant);
      unique case (variant)
         3'h0, 3'h1: selMask = 3'h7;
         3'h2: selMask = 3'h6;
         3'h3: selMask = 3'h4;
         default: selMask = 3'h0;
      endcase
   endfunction

   // byte address mask for a variant
   function automatic logic [ADDR_W-1:0] addrMask(input logic [2:0] variant);
      addrMask = ADDR_W'((ADDR_W'(128) << variant) - ADDR_W'(1));
   endfunction
endpackage

/* hw/i2c_eeprom_slave.sv */
// two-wire serial eeprom slave: link decoder, page buffer, array, ahb-lite regs
// assumes scl/sda/strap pins asynchronous to sys_clk; sda wired open-drain outside
module i2c_eeprom_slave
#(
   parameter int PAGES = eeprom_pkg::MAX_PAGES,
   parameter int PROG_COUNT = eeprom_pkg::PROG_CYCLES,
   parameter int PWRUP_COUNT = eeprom_pkg::PWRUP_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // two-wire link
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   // straps
   input wire eeprom_pkg::strap_t straps,
   // ahb-lite slave
   input wire eeprom_pkg::ahb_req_t ahbReq,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   import eeprom_pkg::*;

   localparam int MEM_BYTES = PAGES * PAGE_BYTES;
   localparam int PCW = $clog2(PROG_COUNT + 1);
   localparam int UCW = $clog2(PWRUP_COUNT + 1);

   // ***************************
   // pin synchronisers
   // ***************************
   logic sclS, sdaS, wpS;
   logic [2:0] selS;
   pin_sync #(.WIDTH(6)) u_sync ( // see R5
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .asyncIn({sclIn, sdaIn, straps.writeProtect, straps.devSelect}),
      .syncOut({sclS, sdaS, wpS, selS})
   );

   // ***************************
   // state
   // ***************************
   logic [7:0] mem [MEM_BYTES];
   link_state_t state_reg, state_next, after_reg, after_next;
   logic sclD_reg, sclD_next, sdaD_reg, sdaD_next;
   logic [3:0] bit_reg, bit_next;
   logic [7:0] shift_reg, shift_next, tx_reg, tx_next;
   logic ackDrv_reg, ackDrv_next, oe_reg, oe_next;
   logic [2:0] devHi_reg, devHi_next;
   logic [ADDR_W-1:0] addr_reg, addr_next, pf_reg, pf_next;
   logic [7:0] page_reg [PAGE_BYTES];
   logic [7:0] page_next [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] valid_reg, valid_next;
   logic busy_reg, busy_next, ready_reg, ready_next;
   logic [PCW-1:0] prog_reg, prog_next;
   logic [UCW-1:0] pwr_reg, pwr_next;
   logic [2:0] cfg_reg, cfg_next;
   logic sclRise, sclFall, startC, stopC, commit, pop;
   logic fifoValid, fifoReady;
   logic [7:0] fifoData, byteIn;

   assign sclRise = sclS && !sclD_reg;
   assign sclFall = !sclS && sclD_reg;
   assign startC = sclS && sclD_reg && sdaD_reg && !sdaS;
   assign stopC = sclS && sclD_reg && !sdaD_reg && sdaS;
   assign byteIn = {shift_reg[6:0], sdaS};
   assign commit = busy_reg && prog_reg == PCW'(PROG_COUNT - 1); // see R8

   // ***************************
   // read prefetch fifo
   // ***************************
   sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .flush(startC),
      .inValid(ready_reg && !busy_reg),
      .inReady(fifoReady),
      .inData(mem[pf_reg]),
      .outValid(fifoValid),
      .outReady(pop),
      .outData(fifoData)
   );

   // ***************************
   // link and write-cycle logic
   // ***************************
   always_comb begin
      state_next = state_reg;
      after_next = after_reg;
      sclD_next = sclS;
      sdaD_next = sdaS;
      bit_next = bit_reg;
      shift_next = shift_reg;
      tx_next = tx_reg;
      ackDrv_next = ackDrv_reg;
      oe_next = oe_reg;
      devHi_next = devHi_reg;
      addr_next = addr_reg;
      pf_next = pf_reg;
      page_next = page_reg;
      valid_next = valid_reg;
      busy_next = busy_reg;
      ready_next = ready_reg;
      prog_next = prog_reg;
      pwr_next = pwr_reg;
      pop = 1'b0;
      if (startC) begin
         pf_next = addr_reg;
      end else if (ready_reg && !busy_reg && fifoReady) begin
         pf_next = (pf_reg + 1'b1) & addrMask(cfg_reg);
      end
      if (!ready_reg) begin
         pwr_next = pwr_reg + 1'b1;
         if (pwr_reg == UCW'(PWRUP_COUNT - 1)) ready_next = 1'b1; // see R7
      end else if (busy_reg) begin
         state_next = ST_IDLE; // see R12
         oe_next = 1'b0; // see R12
         prog_next = prog_reg + 1'b1;
         if (commit) begin
            busy_next = 1'b0;
            valid_next = '0;
         end
      end else if (startC) begin
         state_next = ST_DEV;
         bit_next = '0;
         oe_next = 1'b0;
         valid_next = '0;
      end else if (stopC) begin
         state_next = ST_IDLE;
         oe_next = 1'b0;
         if (valid_reg != '0 && !wpS) begin
            busy_next = 1'b1; // see R2
            prog_next = '0;
         end else begin
            valid_next = '0; // see R6 R11
         end
      end else begin
         unique case (state_reg)
            ST_IDLE: begin
            end
            ST_DEV, ST_WADDR, ST_RX: if (sclRise) begin
               shift_next = byteIn;
               bit_next = bit_reg + 1'b1;
               if (bit_reg == 4'h7) begin
                  state_next = ST_ACK;
                  ackDrv_next = 1'b0;
                  if (state_reg == ST_DEV) begin
                     if (byteIn[7:4] == DEV_TYPE && // see R9
                         ((byteIn[3:1] ^ selS) & selMask(cfg_reg)) == '0) begin // see R4
                        devHi_next = byteIn[3:1];
                        after_next = byteIn[0] ? ST_TX : ST_WADDR; // see R9
                     end else begin
                        state_next = ST_IDLE;
                     end
                  end else if (state_reg == ST_WADDR) begin
                     addr_next = {devHi_reg & ~selMask(cfg_reg), byteIn} & addrMask(cfg_reg);
                     after_next = ST_RX;
                  end else begin
                     page_next[addr_reg[3:0]] = byteIn; // see R2
                     valid_next[addr_reg[3:0]] = 1'b1;
                     addr_next = {addr_reg[ADDR_W-1:4], addr_reg[3:0] + 4'h1}; // see R10
                     after_next = ST_RX;
                  end
               end
            end
            ST_ACK: if (sclFall) begin
               bit_next = '0;
               if (!ackDrv_reg) begin
                  oe_next = 1'b1;
                  ackDrv_next = 1'b1;
               end else begin
                  state_next = after_reg;
                  oe_next = 1'b0;
                  if (after_reg == ST_TX) begin
                     tx_next = fifoValid ? fifoData : IDLE_BYTE;
                     pop = fifoValid;
                     oe_next = !tx_next[7];
                  end
               end
            end
            ST_TX: begin
               if (sclRise) begin
                  bit_next = bit_reg + 1'b1;
                  if (bit_reg == 4'h7) begin
                     state_next = ST_MACK;
                     ackDrv_next = 1'b0;
                     addr_next = (addr_reg + 1'b1) & addrMask(cfg_reg); // see R3
                  end
               end else if (sclFall) begin
                  tx_next = {tx_reg[6:0], 1'b1};
                  oe_next = !tx_next[7];
               end
            end
            ST_MACK: begin
               if (sclFall && !ackDrv_reg) begin
                  oe_next = 1'b0;
               end else if (sclRise) begin
                  if (sdaS) state_next = ST_IDLE;
                  else ackDrv_next = 1'b1;
               end else if (sclFall) begin
                  state_next = ST_TX;
                  bit_next = '0;
                  tx_next = fifoValid ? fifoData : IDLE_BYTE;
                  pop = fifoValid;
                  oe_next = !tx_next[7];
               end
            end
            default: state_next = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_reg <= ST_IDLE;
         after_reg <= ST_IDLE;
         sclD_reg <= 1'b1;
         sdaD_reg <= 1'b1;
         bit_reg <= '0;
         shift_reg <= '0;
         tx_reg <= '0;
         ackDrv_reg <= 1'b0;
         oe_reg <= 1'b0;
         devHi_reg <= '0;
         addr_reg <= '0;
         pf_reg <= '0;
         valid_reg <= '0;
         busy_reg <= 1'b0;
         ready_reg <= 1'b0;
         prog_reg <= '0;
         pwr_reg <= '0;
      end else begin
         state_reg <= state_next;
         after_reg <= after_next;
         sclD_reg <= sclD_next;
         sdaD_reg <= sdaD_next;
         bit_reg <= bit_next;
         shift_reg <= shift_next;
         tx_reg <= tx_next;
         ackDrv_reg <= ackDrv_next;
         oe_reg <= oe_next;
         devHi_reg <= devHi_next;
         addr_reg <= addr_next;
         pf_reg <= pf_next;
         valid_reg <= valid_next;
         busy_reg <= busy_next;
         ready_reg <= ready_next;
         prog_reg <= prog_next;
         pwr_reg <= pwr_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      page_reg <= page_next;
   end

   // buffered bytes of the page committed in the one programming cycle
   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
         if (commit && valid_reg[i]) mem[{addr_reg[ADDR_W-1:4], 4'(i)}] <= page_reg[i]; // see R1 R2
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe = oe_reg;

   // ***************************
   // ahb-lite registers
   // ***************************
   logic wrPend_reg, wrPend_next;
   logic [7:0] wrAddr_reg, wrAddr_next;
   logic [31:0] rdata_reg, rdata_next;
   logic apValid;

   assign apValid = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;

   always_comb begin
      wrPend_next = apValid && ahbReq.hwrite;
      wrAddr_next = ahbReq.haddr[7:0];
      rdata_next = rdata_reg;
      cfg_next = cfg_reg;
      if (wrPend_reg && wrAddr_reg == CFG_OFS && ahbReq.hwdata[2:0] <= VARIANT_MAX) begin
         cfg_next = ahbReq.hwdata[2:0]; // see R1 R4
      end
      if (apValid && !ahbReq.hwrite) begin
         rdata_next = '0;
         unique case (ahbReq.haddr[7:0])
            CFG_OFS: rdata_next[2:0] = cfg_next;
            STAT_OFS: begin
               rdata_next[STAT_READY] = ready_reg;
               rdata_next[STAT_BUSY] = busy_reg;
               rdata_next[STAT_WP] = wpS;
               rdata_next[STAT_ACTIVE] = state_reg != ST_IDLE;
            end
            ADDR_OFS: rdata_next[ADDR_W-1:0] = addr_reg;
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= '0;
         rdata_reg <= '0;
         cfg_reg <= VARIANT_RST;
      end else begin
         wrPend_reg <= wrPend_next;
         wrAddr_reg <= wrAddr_next;
         rdata_reg <= rdata_next;
         cfg_reg <= cfg_next;
      end
   end

   assign hrdata = rdata_reg;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
endmodule // i2c_eeprom_slave

/* hw/pin_sync.sv */
// two-stage synchroniser for pins from outside the sys_clk domain
// assumes inputs may change at any time
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // pins and synchronised levels
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_reg, meta_next;
   logic [WIDTH-1:0] sync_reg, sync_next;

   always_comb begin
      meta_next = asyncIn;
      sync_next = meta_reg;
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign syncOut = sync_reg;
endmodule // pin_sync

/* hw/sync_fifo.sv */
// synchronous fifo with valid/ready on both sides and a flush
// assumes one clock domain
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic flush,
   // fill side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // drain side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [PW-1:0] wr_reg, wr_next, rd_reg, rd_next;
   logic [PW:0] cnt_reg, cnt_next;
   logic push, pop;

   assign inReady = cnt_reg != (PW+1)'(DEPTH);
   assign outValid = cnt_reg != '0;
   assign outData = mem[rd_reg];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      wr_next = wr_reg;
      rd_next = rd_reg;
      cnt_next = cnt_reg;
      if (flush) begin
         wr_next = '0;
         rd_next = '0;
         cnt_next = '0;
      end else begin
         if (push) wr_next = PW'((wr_reg + 1'b1) % DEPTH);
         if (pop) rd_next = PW'((rd_reg + 1'b1) % DEPTH);
         cnt_next = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push && !flush) mem[wr_reg] <= inData;
   end
endmodule // sync_fifo

/* test/eeprom_asserts.sv */
// concurrent checks on the serial eeprom slave ports
// assumes binding into i2c_eeprom_slave, one sys_clk domain
module eeprom_asserts
#(
   parameter int PAGES = 128,
   parameter int PROG_COUNT = 100000,
   parameter int PWRUP_COUNT = 20000
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset_n,
   // two-wire link
   input wire logic sclIn,
   input wire logic sdaIn,
   input wire logic sdaOut,
   input wire logic sdaOe,
   // straps and ahb-lite
   input wire eeprom_pkg::strap_t straps,
   input wire eeprom_pkg::ahb_req_t ahbReq,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp
);
   import eeprom_pkg::*;
   int pwrCnt;
   int fallCnt;
   logic cfgWr;
   logic [2:0] cfgShadow;
   logic taken;
   logic rdTaken;
   logic [7:0] ofs;
   assign taken = ahbReq.hsel && ahbReq.htrans[1] && ahbReq.hready;
   assign rdTaken = taken && !ahbReq.hwrite;
   assign ofs = ahbReq.haddr[7:0];
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // ********
   // helper state
   // ********
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         pwrCnt <= 0;
         fallCnt <= 99;
         cfgWr <= 1'b0;
         cfgShadow <= VARIANT_RST;
      end else begin
         if (pwrCnt < PWRUP_COUNT) begin
            pwrCnt <= pwrCnt + 1;
         end
         if ($fell(sclIn)) begin
            fallCnt <= 0;
         end else if (fallCnt < 99) begin
            fallCnt <= fallCnt + 1;
         end
         cfgWr <= taken && ahbReq.hwrite && ofs == CFG_OFS;
         if (cfgWr && ahbReq.hwdata[2:0] <= 3'h4) begin
            cfgShadow <= ahbReq.hwdata[2:0];
         end
      end
   end
   // ********
   // assertions
   // ********
   okay_resp_a: assert property (hreadyout && !hresp)
      else $error("bus response not okay");
   open_drain_a: assert property (sdaOut == 1'b0)
      else $error("sda driven high");
   reset_quiet_a: assert property ($rose(reset_n) |-> hrdata == 32'h0 && !sdaOe)
      else $error("outputs not at reset values");
   pwrup_quiet_a: assert property (pwrCnt < PWRUP_COUNT |-> !sdaOe)
      else $error("sda driven during power-up");
   pwrup_status_a: assert property (rdTaken && ofs == STAT_OFS && pwrCnt + 4 < PWRUP_COUNT
      |-> ##1 !hrdata[STAT_READY])
      else $error("ready shown during power-up");
   unmapped_zero_a: assert property (rdTaken && ofs > ADDR_OFS |-> ##1 hrdata == 32'h0)
      else $error("unmapped read not zero");
   cfg_read_a: assert property (rdTaken && ofs == CFG_OFS
      |-> ##1 hrdata == {29'h0, cfgShadow})
      else $error("config read mismatch");
   oe_edge_a: assert property ($changed(sdaOe) |-> fallCnt <= 5)
      else $error("sda drive changed away from scl fall");
endmodule // eeprom_asserts

bind i2c_eeprom_slave eeprom_asserts #(
   .PAGES(PAGES), .PROG_COUNT(PROG_COUNT), .PWRUP_COUNT(PWRUP_COUNT)
) eeprom_asserts_i (
   .sys_clk(sys_clk), .reset_n(reset_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
   .sdaOe(sdaOe), .straps(straps), .ahbReq(ahbReq), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp)
);

/* test/i2c_master_model.sv */
// two-wire bus master model: drives scl, pulls sda low open-drain
// assumes sda resolved outside with a pull-up; scl stands high between frames
module i2c_master_model (
   // link
   output logic scl,
   output logic sdaPull,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int Q = 100;
   initial begin
      scl = 1'b1;
      sdaPull = 1'b0;
   end
   task automatic bitOut(input logic b);
      #Q sdaPull = !b;
      #Q scl = 1'b1;
      #(2 * Q) scl = 1'b0;
   endtask
   task automatic bitIn(output logic b);
      #Q sdaPull = 1'b0;
      #Q scl = 1'b1;
      #Q b = sda;
      #Q scl = 1'b0;
   endtask
   task automatic start();
      #13 sdaPull = 1'b0;
      #Q scl = 1'b1;
      #Q sdaPull = 1'b1;
      #Q scl = 1'b0;
   endtask
   task automatic stop();
      #Q sdaPull = 1'b1;
      #Q scl = 1'b1;
      #Q sdaPull = 1'b0;
      #(2 * Q);
   endtask
   // msb first, ninth bit is the acknowledge
   task automatic sendByte(input logic [7:0] d, output logic nak);
      for (int i = 7; i >= 0; i--) begin
         bitOut(d[i]);
      end
      bitIn(nak);
   endtask
   task automatic recvByte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         bitIn(d[i]);
      end
      bitOut(last);
   endtask
endmodule // i2c_master_model

/* test/tb_top.sv */
// self-checking bench for the serial eeprom slave
// assumes the master model and checker compile ahead of it
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import eeprom_pkg::*;
   localparam int PROG = 400;
   localparam int PWRUP = 50;
   logic sys_clk;
   logic reset_n;
   logic scl;
   logic sdaPull;
   logic sda;
   logic sdaOut;
   logic sdaOe;
   strap_t straps;
   ahb_req_t busReq;
   ahb_req_t ahbReq;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   int fails;
   int testsRun;
   logic [31:0] rd;
   logic nak;
   logic [7:0] rb;
   logic [7:0] img [0:15];
   assign sda = !((sdaOe && !sdaOut) || sdaPull);
   always_comb begin
      ahbReq = busReq;
      ahbReq.hready = hreadyout;
   end
   i2c_eeprom_slave #(
      .PAGES(128), .PROG_COUNT(PROG), .PWRUP_COUNT(PWRUP)
   ) i2c_eeprom_slave_i (
      .sys_clk(sys_clk), .reset_n(reset_n), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
      .sdaOe(sdaOe), .straps(straps), .ahbReq(ahbReq), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp)
   );
   i2c_master_model i2c_master_model_i (.scl(scl), .sdaPull(sdaPull), .sda(sda));
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   // ********
   // shared tasks
   // ********
   task automatic test_done();
      if (fails == 0 && testsRun > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chkWord(input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t word exp %h got %h", $time, exp, got);
      end
   endtask
   task automatic chkLink(input logic [7:0] exp, input logic [7:0] got);
      testsRun++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t link exp %h got %h", $time, exp, got);
      end
   endtask
   task automatic waitReady();
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fails++;
         test_done();
      end
   endtask
   task automatic ahb(input logic [7:0] a, input logic wr, input logic [31:0] wd);
      @(posedge sys_clk);
      busReq.hsel <= 1'b1;
      busReq.haddr <= {24'h0, a};
      busReq.htrans <= 2'b10;
      busReq.hwrite <= wr;
      busReq.hsize <= 3'b010;
      waitReady();
      busReq.htrans <= 2'b00;
      busReq.hwdata <= wd;
      waitReady();
      rd = hrdata;
   endtask
   task automatic waitStatus(input int b, input logic v);
      int n;
      n = 0;
      do begin
         ahb(STAT_OFS, 1'b0, 32'h0);
         n++;
      end while (rd[b] !== v && n < 300);
      chkWord({31'h0, v}, {31'h0, rd[b]});
   endtask
   task automatic send(input logic [7:0] d, input logic expNak);
      i2c_master_model_i.sendByte(d, nak);
      chkLink({7'h0, expNak}, {7'h0, nak});
   endtask
   task automatic probe(input logic [7:0] d, input logic expNak);
      i2c_master_model_i.start();
      send(d, expNak);
      i2c_master_model_i.stop();
   endtask
   task automatic readPage(input logic [3:0] off, input int n);
      i2c_master_model_i.start();
      send(8'hA2, 1'b0);
      send(8'h30 + 8'(off), 1'b0);
      i2c_master_model_i.start();
      send(8'hA3, 1'b0);
      for (int i = 0; i < n; i++) begin
         i2c_master_model_i.recvByte(i == n - 1, rb);
         chkLink(img[off + 4'(i)], rb);
      end
      i2c_master_model_i.stop();
   endtask
   // ********
   // scenarios
   // ********
   task automatic resetCheck();
      ahb(CFG_OFS, 1'b0, 32'h0);
      chkWord({29'h0, VARIANT_RST}, rd);
      ahb(STAT_OFS, 1'b0, 32'h0);
      chkWord(32'h0, rd & 32'h5);
      ahb(8'h0C, 1'b0, 32'h0);
      chkWord(32'h0, rd);
      probe(8'hA2, 1'b1);
      waitStatus(STAT_READY, 1'b1);
   endtask
   task automatic pageWrite();
      i2c_master_model_i.start();
      send(8'hA2, 1'b0);
      send(8'h30, 1'b0);
      for (int i = 0; i < 17; i++) begin
         send(8'h40 + 8'(i), 1'b0);
         img[i % 16] = 8'h40 + 8'(i);
      end
      i2c_master_model_i.stop();
      ahb(STAT_OFS, 1'b0, 32'h0);
      chkWord(32'h2, rd & 32'h2);
      probe(8'hA2, 1'b1);
      waitStatus(STAT_BUSY, 1'b0);
   endtask
   task automatic pageRead();
      readPage(4'h0, 16);
      ahb(ADDR_OFS, 1'b1, 32'h7FF);
      ahb(ADDR_OFS, 1'b0, 32'h0);
      chkWord(32'h140, rd);
   endtask
   task automatic selectCheck();
      ahb(CFG_OFS, 1'b1, 32'h0);
      ahb(CFG_OFS, 1'b1, 32'h7);
      ahb(CFG_OFS, 1'b0, 32'h0);
      chkWord(32'h0, rd);
      straps.devSelect <= 3'h5;
      probe(8'hAA, 1'b0);
      probe(8'hA6, 1'b1);
      probe(8'hBA, 1'b1);
      ahb(CFG_OFS, 1'b1, 32'h4);
   endtask
   task automatic protectCheck();
      straps.writeProtect <= 1'b1;
      ahb(STAT_OFS, 1'b0, 32'h0);
      ahb(STAT_OFS, 1'b0, 32'h0);
      chkWord(32'h4, rd & 32'h6);
      i2c_master_model_i.start();
      send(8'hA2, 1'b0);
      send(8'h31, 1'b0);
      send(8'h99, 1'b0);
      i2c_master_model_i.stop();
      ahb(STAT_OFS, 1'b0, 32'h0);
      chkWord(32'h4, rd & 32'h6);
      straps.writeProtect <= 1'b0;
      readPage(4'h1, 1);
   endtask
   initial begin
      fails = 0;
      testsRun = 0;
      reset_n = 1'b0;
      straps = '0;
      busReq = '0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      resetCheck();
      pageWrite();
      pageRead();
      selectCheck();
      protectCheck();
      test_done();
   end
endmodule // tb_top
